// File: design/mem_port_defines.svh
`ifndef MEM_PORT_DEFINES_SVH
`define MEM_PORT_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_PROG_BANK1_BOUNDARY 8'h00
`define OFF_DATA_BANK1_BOUNDARY 8'h04
`define OFF_DATA_BANK2_BOUNDARY 8'h08
`define OFF_DATA_BANK3_BOUNDARY 8'h0C
`define OFF_PROG_WAIT_CONTROL 8'h10
`define OFF_DATA_WAIT_CONTROL 8'h14
`define OFF_PORT_STATUS 8'h18

// ****************************************
// Reset values
// ****************************************
`define RST_PROG_BANK1_BOUNDARY 24'h800000
`define RST_DATA_BANK1_BOUNDARY 32'h20000000
`define RST_DATA_BANK2_BOUNDARY 32'h40000000
`define RST_DATA_BANK3_BOUNDARY 32'h80000000
`define RST_PROG_WAIT_CONTROL 14'h0000
`define RST_DATA_WAIT_CONTROL 24'h000000

// ****************************************
// Field positions and response codes
// ****************************************
`define WAIT_FIELD_STRIDE 5'h05
`define MODE_BIT_REVERSE 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: design/mem_port_pkg.sv
package mem_port_pkg;

  typedef enum logic [1:0] {
    WAIT_EXTERNAL,
    WAIT_INTERNAL,
    WAIT_BOTH,
    WAIT_EITHER
  } wait_mode_e;

  typedef struct packed {
    logic [2:0] count;
    wait_mode_e mode;
  } wait_field_s;

  typedef enum logic {
    PORT_IDLE,
    PORT_ACCESS
  } port_state_e;

  typedef struct packed {
    logic write;
    logic abort;
    logic index_zero;
    logic [31:0] addr;
    logic [47:0] wdata;
  } mem_req_s;

endpackage

// File: design/banked_memory_port_waitstates.sv
// How it works
// - Read drives address, select, strobe, waits, captures.
// - False-condition read: select only, no strobe.
// - Write strobes with data, then releases and floats.
// - False-condition write: select only, no drive.
// - Float request undrives pins, ignores acknowledge.
// - Float at once; resume access when released.
// - Floated port stalls only accesses on it.
// - Float covers address, data, selects, strobes, page.
// - Program bank 1 from its boundary upward.
// - Data space decodes into four banks.
// - Bit-reverse index-zero accesses use bank 0.
// - Boundary registers load documented reset values.
// - External mode: acknowledge low adds wait.
// - Internal mode: fixed count zero to seven.
// - Both mode: count expired and acknowledge high.
// - Either mode: first of acknowledge or count.
// - Two-bit mode code selects per-bank method.
// - Program wait fields per bank layout.
// - Data wait fields per bank layout.
// - Data address holds until next change.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_defines.svh"
module banked_memory_port_waitstates (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire mem_port_pkg::mem_req_s prog_req,
  input wire logic prog_req_valid,
  output logic prog_done,
  output logic [47:0] prog_rdata,
  input wire mem_port_pkg::mem_req_s data_req,
  input wire logic data_req_valid,
  output logic data_done,
  output logic [39:0] data_rdata,
  input wire logic [31:0] core_mode_word,
  input wire logic bit_reverse_instr,
  input wire logic [31:0] bit_reverse_addr,
  output logic [23:0] prog_addr_out,
  output logic [1:0] prog_bank_select_n,
  output logic prog_read_strobe_n,
  output logic prog_write_strobe_n,
  input wire logic [47:0] prog_data_in,
  output logic [47:0] prog_data_out,
  output logic prog_data_oe,
  output logic prog_pins_oe,
  output logic prog_page_cross,
  input wire logic prog_acknowledge,
  input wire logic prog_float_request_n,
  output logic [31:0] data_addr_out,
  output logic [3:0] data_bank_select_n,
  output logic data_read_strobe_n,
  output logic data_write_strobe_n,
  input wire logic [39:0] data_data_in,
  output logic [39:0] data_data_out,
  output logic data_data_oe,
  output logic data_pins_oe,
  output logic data_page_cross,
  input wire logic data_acknowledge,
  input wire logic data_float_request_n
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // Functions
  // ****************************************
  function automatic mem_port_pkg::wait_field_s wait_field(
    input logic [23:0] ctl, input logic [1:0] bank);
    logic [23:0] s;
    s = ctl >> (5'(bank) * `WAIT_FIELD_STRIDE);
    return mem_port_pkg::wait_field_s'(s[4:0]);
  endfunction

  function automatic logic wait_done(input mem_port_pkg::wait_mode_e m,
    input logic expired, input logic ack);
    logic r;
    r = ack;
    case (m)
      mem_port_pkg::WAIT_EXTERNAL: r = ack;
      mem_port_pkg::WAIT_INTERNAL: r = expired;
      mem_port_pkg::WAIT_BOTH: r = expired & ack;
      mem_port_pkg::WAIT_EITHER: r = expired | ack;
      default: r = ack;
    endcase
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return a == `OFF_PROG_BANK1_BOUNDARY || a == `OFF_DATA_BANK1_BOUNDARY ||
      a == `OFF_DATA_BANK2_BOUNDARY || a == `OFF_DATA_BANK3_BOUNDARY ||
      a == `OFF_PROG_WAIT_CONTROL || a == `OFF_DATA_WAIT_CONTROL ||
      a == `OFF_PORT_STATUS;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic reg_we;
  logic [23:0] prog_b1_q;
  logic [31:0] data_b1_q, data_b2_q, data_b3_q;
  logic [13:0] prog_wait_q;
  logic [23:0] data_wait_q;
  logic [31:0] status;
  logic [31:0] rd_val;

  assign reg_we = aw_got_q & w_got_q & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (reg_we) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Boundary and wait registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_b1_q <= `RST_PROG_BANK1_BOUNDARY;
      data_b1_q <= `RST_DATA_BANK1_BOUNDARY;
      data_b2_q <= `RST_DATA_BANK2_BOUNDARY;
      data_b3_q <= `RST_DATA_BANK3_BOUNDARY;
      prog_wait_q <= `RST_PROG_WAIT_CONTROL;
      data_wait_q <= `RST_DATA_WAIT_CONTROL;
    end else if (reg_we) begin
      case (awaddr_q)
        `OFF_PROG_BANK1_BOUNDARY:
          prog_b1_q <= 24'(merge({8'h00, prog_b1_q}, wdata_q, wstrb_q));
        `OFF_DATA_BANK1_BOUNDARY: data_b1_q <= merge(data_b1_q, wdata_q, wstrb_q);
        `OFF_DATA_BANK2_BOUNDARY: data_b2_q <= merge(data_b2_q, wdata_q, wstrb_q);
        `OFF_DATA_BANK3_BOUNDARY: data_b3_q <= merge(data_b3_q, wdata_q, wstrb_q);
        `OFF_PROG_WAIT_CONTROL:
          prog_wait_q <= 14'(merge({18'h00000, prog_wait_q}, wdata_q,
            wstrb_q));
        `OFF_DATA_WAIT_CONTROL:
          data_wait_q <= 24'(merge({8'h00, data_wait_q}, wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    case (araddr)
      `OFF_PROG_BANK1_BOUNDARY: rd_val = {8'h00, prog_b1_q};
      `OFF_DATA_BANK1_BOUNDARY: rd_val = data_b1_q;
      `OFF_DATA_BANK2_BOUNDARY: rd_val = data_b2_q;
      `OFF_DATA_BANK3_BOUNDARY: rd_val = data_b3_q;
      `OFF_PROG_WAIT_CONTROL: rd_val = {18'h00000, prog_wait_q};
      `OFF_DATA_WAIT_CONTROL: rd_val = {8'h00, data_wait_q};
      `OFF_PORT_STATUS: rd_val = status;
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= reg_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Program port
  // ****************************************
  mem_port_pkg::port_state_e prog_st_q;
  mem_port_pkg::wait_field_s prog_field;
  mem_port_pkg::wait_mode_e prog_mode_q;
  logic [2:0] prog_cnt_q;
  logic prog_wr_q, prog_abort_q, prog_bank_q, prog_bank;
  logic prog_start, prog_finish;

  assign prog_bank = (prog_req.addr[23:0] >= prog_b1_q);
  assign prog_field = wait_field({10'h000, prog_wait_q}, {1'b0, prog_bank});
  assign prog_start = (prog_st_q == mem_port_pkg::PORT_IDLE) &
    prog_req_valid & ~prog_done;
  assign prog_finish = (prog_st_q == mem_port_pkg::PORT_ACCESS) &
    prog_float_request_n &
    wait_done(prog_mode_q, prog_cnt_q == 3'h0, prog_acknowledge);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_st_q <= mem_port_pkg::PORT_IDLE;
      prog_mode_q <= mem_port_pkg::WAIT_EXTERNAL;
      prog_cnt_q <= 3'h0;
      prog_wr_q <= 1'b0;
      prog_abort_q <= 1'b0;
      prog_bank_q <= 1'b0;
      prog_addr_out <= 24'h000000;
      prog_bank_select_n <= 2'h3;
      prog_read_strobe_n <= 1'b1;
      prog_write_strobe_n <= 1'b1;
      prog_data_out <= 48'h000000000000;
      prog_data_oe <= 1'b0;
      prog_done <= 1'b0;
      prog_rdata <= 48'h000000000000;
    end else begin
      prog_done <= 1'b0;
      case (prog_st_q)
        mem_port_pkg::PORT_IDLE: begin
          prog_data_oe <= 1'b0;
          if (prog_start) begin
            prog_st_q <= mem_port_pkg::PORT_ACCESS;
            prog_addr_out <= prog_req.addr[23:0];
            prog_bank_q <= prog_bank;
            prog_bank_select_n <= ~(2'h1 << prog_bank);
            prog_cnt_q <= prog_field.count;
            prog_mode_q <= prog_field.mode;
            prog_wr_q <= prog_req.write;
            prog_abort_q <= prog_req.abort;
            prog_read_strobe_n <= prog_req.write | prog_req.abort;
            prog_write_strobe_n <= ~prog_req.write | prog_req.abort;
            prog_data_out <= prog_req.wdata;
            prog_data_oe <= prog_req.write & ~prog_req.abort &
              prog_float_request_n;
          end
        end
        mem_port_pkg::PORT_ACCESS: begin
          if (prog_cnt_q != 3'h0) begin
            prog_cnt_q <= prog_cnt_q - 3'h1;
          end
          prog_data_oe <= prog_wr_q & ~prog_abort_q & prog_float_request_n;
          if (prog_finish) begin
            prog_st_q <= mem_port_pkg::PORT_IDLE;
            prog_read_strobe_n <= 1'b1;
            prog_write_strobe_n <= 1'b1;
            prog_data_oe <= 1'b0;
            prog_done <= 1'b1;
            if (!prog_wr_q && !prog_abort_q) begin
              prog_rdata <= prog_data_in;
            end
          end
        end
        default: prog_st_q <= mem_port_pkg::PORT_IDLE;
      endcase
    end
  end

  // ****************************************
  // Data port
  // ****************************************
  mem_port_pkg::port_state_e data_st_q;
  mem_port_pkg::wait_field_s data_field;
  mem_port_pkg::wait_mode_e data_mode_q;
  logic [2:0] data_cnt_q;
  logic data_wr_q, data_abort_q;
  logic [1:0] data_bank_q, data_bank;
  logic data_start, data_finish;

  always_comb begin
    if (data_req.addr < data_b1_q) begin
      data_bank = 2'h0;
    end else if (data_req.addr < data_b2_q) begin
      data_bank = 2'h1;
    end else if (data_req.addr < data_b3_q) begin
      data_bank = 2'h2;
    end else begin
      data_bank = 2'h3;
    end
    if (core_mode_word[`MODE_BIT_REVERSE] && data_req.index_zero) begin
      data_bank = 2'h0;
    end
  end

  assign data_field = wait_field(data_wait_q, data_bank);
  assign data_start = (data_st_q == mem_port_pkg::PORT_IDLE) &
    data_req_valid & ~data_done;
  assign data_finish = (data_st_q == mem_port_pkg::PORT_ACCESS) &
    data_float_request_n &
    wait_done(data_mode_q, data_cnt_q == 3'h0, data_acknowledge);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_st_q <= mem_port_pkg::PORT_IDLE;
      data_mode_q <= mem_port_pkg::WAIT_EXTERNAL;
      data_cnt_q <= 3'h0;
      data_wr_q <= 1'b0;
      data_abort_q <= 1'b0;
      data_bank_q <= 2'h0;
      data_addr_out <= 32'h00000000;
      data_bank_select_n <= 4'hF;
      data_read_strobe_n <= 1'b1;
      data_write_strobe_n <= 1'b1;
      data_data_out <= 40'h0000000000;
      data_data_oe <= 1'b0;
      data_done <= 1'b0;
      data_rdata <= 40'h0000000000;
    end else begin
      data_done <= 1'b0;
      case (data_st_q)
        mem_port_pkg::PORT_IDLE: begin
          data_data_oe <= 1'b0;
          if (data_start) begin
            data_st_q <= mem_port_pkg::PORT_ACCESS;
            data_addr_out <= data_req.addr;
            data_bank_q <= data_bank;
            data_bank_select_n <= ~(4'h1 << data_bank);
            data_cnt_q <= data_field.count;
            data_mode_q <= data_field.mode;
            data_wr_q <= data_req.write;
            data_abort_q <= data_req.abort;
            data_read_strobe_n <= data_req.write | data_req.abort;
            data_write_strobe_n <= ~data_req.write | data_req.abort;
            data_data_out <= data_req.wdata[39:0];
            data_data_oe <= data_req.write & ~data_req.abort &
              data_float_request_n;
          end else if (bit_reverse_instr) begin
            data_addr_out <= bit_reverse_addr;
          end
        end
        mem_port_pkg::PORT_ACCESS: begin
          if (data_cnt_q != 3'h0) begin
            data_cnt_q <= data_cnt_q - 3'h1;
          end
          // this port waits only on its own float
          data_data_oe <= data_wr_q & ~data_abort_q & data_float_request_n;
          if (data_finish) begin
            data_st_q <= mem_port_pkg::PORT_IDLE;
            data_read_strobe_n <= 1'b1;
            data_write_strobe_n <= 1'b1;
            data_data_oe <= 1'b0;
            data_done <= 1'b1;
            if (!data_wr_q && !data_abort_q) begin
              data_rdata <= data_data_in;
            end
          end
        end
        default: data_st_q <= mem_port_pkg::PORT_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin drive and status
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_pins_oe <= 1'b1;
      data_pins_oe <= 1'b1;
      prog_page_cross <= 1'b0;
      data_page_cross <= 1'b0;
    end else begin
      prog_pins_oe <= prog_float_request_n;
      data_pins_oe <= data_float_request_n;
      prog_page_cross <= 1'b0;
      data_page_cross <= 1'b0;
    end
  end

  assign status = {24'h000000, data_bank_q, 1'b0, prog_bank_q,
    ~data_pins_oe, ~prog_pins_oe,
    data_st_q == mem_port_pkg::PORT_ACCESS,
    prog_st_q == mem_port_pkg::PORT_ACCESS};

  // ****************************************
  // Assertions
  // ****************************************

  sequence s_data_write_start;
    data_start && data_req.write && !data_req.abort && data_float_request_n;
  endsequence
  sequence s_write_driving;
    !data_write_strobe_n && data_data_oe;
  endsequence

  property p_prog_bank_sel;
    prog_start |=> prog_bank_select_n[0] == (prog_addr_out >= prog_b1_q);
  endproperty
  a_prog_bank_sel: assert property (p_prog_bank_sel)
    else $error("program select does not match boundary");

  property p_abort_no_strobe;
    (data_start && data_req.abort) |=>
      (data_read_strobe_n && data_write_strobe_n && !data_data_oe)
      until (data_st_q == mem_port_pkg::PORT_IDLE);
  endproperty
  a_abort_no_strobe: assert property (p_abort_no_strobe)
    else $error("aborted access raised a strobe");

  property p_write_drive;
    s_data_write_start |=> s_write_driving;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write strobe or data drive missing");

  property p_float_pins;
    !data_float_request_n |=> !data_pins_oe && !data_data_oe;
  endproperty
  a_float_pins: assert property (p_float_pins)
    else $error("data port still driving while floated");

  property p_external_done;
    (data_st_q == mem_port_pkg::PORT_ACCESS && data_float_request_n &&
     data_mode_q == mem_port_pkg::WAIT_EXTERNAL && data_acknowledge)
      |=> data_done && data_read_strobe_n && data_write_strobe_n;
  endproperty
  a_external_done: assert property (p_external_done)
    else $error("external mode did not complete on acknowledge");

  property p_internal_wait;
    (prog_st_q == mem_port_pkg::PORT_ACCESS &&
     prog_mode_q != mem_port_pkg::WAIT_EXTERNAL &&
     prog_mode_q != mem_port_pkg::WAIT_EITHER && prog_cnt_q != 3'h0)
      |=> !prog_done;
  endproperty
  a_internal_wait: assert property (p_internal_wait)
    else $error("access ended before wait count expired");

  property p_both_needs_ack;
    (data_st_q == mem_port_pkg::PORT_ACCESS &&
     data_mode_q == mem_port_pkg::WAIT_BOTH && !data_acknowledge)
      |=> !data_done && data_st_q == mem_port_pkg::PORT_ACCESS;
  endproperty
  a_both_needs_ack: assert property (p_both_needs_ack)
    else $error("both mode finished without acknowledge");

  property p_either_done;
    (prog_st_q == mem_port_pkg::PORT_ACCESS && prog_float_request_n &&
     prog_mode_q == mem_port_pkg::WAIT_EITHER && prog_cnt_q == 3'h0)
      |=> prog_done;
  endproperty
  a_either_done: assert property (p_either_done)
    else $error("either mode did not finish on expiry");

  property p_addr_hold;
    (!data_start && !bit_reverse_instr) |=> $stable(data_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("data address changed without cause");

  property p_bit_reverse_instr_bank0;
    (data_start && core_mode_word[`MODE_BIT_REVERSE] && data_req.index_zero)
      |=> data_bank_select_n == 4'hE;
  endproperty
  a_bit_reverse_instr_bank0: assert property (p_bit_reverse_instr_bank0)
    else $error("bit-reverse access did not select bank 0");

endmodule
`default_nettype wire

// File: tb/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mem_partner #(parameter int DW = 40) (
  input wire logic aclk,
  input wire logic [3:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [DW-1:0] dout,
  input wire logic oe,
  input wire logic [2:0] dly,
  output logic [DW-1:0] din,
  output logic ack
);
  logic [DW-1:0] mem [16];
  logic [DW-1:0] last_q;
  logic [3:0] cnt_q;
  assign ack = (!rd_n || !wr_n) && cnt_q >= {1'b0, dly};
  // Released bus toggles
  assign din = rd_n ? ~last_q : mem[addr];
  always_ff @(posedge aclk) begin
    cnt_q <= (rd_n && wr_n) ? 4'h0 : cnt_q + 4'h1;
    last_q <= din;
    if (!wr_n && oe) mem[addr] <= dout;
  end
endmodule
`default_nettype wire

// File: tb/test_banked_memory_port_waitstates.sv
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_defines.svh"
`define CHK(t, e, s) begin n_compared++; if ((s) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", t, e, s); \
  end end
module test_banked_memory_port_waitstates;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, prog_req_valid, prog_done;
  logic data_req_valid, data_done, bit_reverse_instr, prog_read_strobe_n;
  logic prog_write_strobe_n, prog_data_oe, prog_pins_oe, prog_acknowledge;
  logic prog_float_request_n, data_read_strobe_n, data_write_strobe_n;
  logic data_data_oe, data_pins_oe, data_acknowledge, data_float_request_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, core_mode_word, bit_reverse_addr, data_addr_out;
  logic [3:0] wstrb, data_bank_select_n, sel;
  logic [1:0] bresp, rresp, prog_bank_select_n, m;
  logic [47:0] prog_rdata, prog_data_in, prog_data_out;
  logic [39:0] data_rdata, data_data_in, data_data_out, wd;
  logic [23:0] prog_addr_out;
  logic [2:0] dly;
  logic [31:0] v, a;
  mem_port_pkg::mem_req_s prog_req, data_req;
  int fail_count, n_compared, cyc, seed, n, low, b, c, d, k;
  banked_memory_port_waitstates i_dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .prog_req,
    .prog_req_valid, .prog_done, .prog_rdata, .data_req, .data_req_valid,
    .data_done, .data_rdata, .core_mode_word, .bit_reverse_instr,
    .bit_reverse_addr, .prog_addr_out, .prog_bank_select_n,
    .prog_read_strobe_n, .prog_write_strobe_n, .prog_data_in, .prog_data_out,
    .prog_data_oe, .prog_pins_oe, .prog_page_cross(), .prog_acknowledge,
    .prog_float_request_n, .data_addr_out, .data_bank_select_n,
    .data_read_strobe_n, .data_write_strobe_n, .data_data_in, .data_data_out,
    .data_data_oe, .data_pins_oe, .data_page_cross(), .data_acknowledge,
    .data_float_request_n);
  mem_partner #(.DW(48)) i_pmem (.aclk, .addr(prog_addr_out[3:0]),
    .rd_n(prog_read_strobe_n), .wr_n(prog_write_strobe_n),
    .dout(prog_data_out), .oe(prog_data_oe), .dly(3'h0),
    .din(prog_data_in), .ack(prog_acknowledge));
  mem_partner #(.DW(40)) i_dmem (.aclk, .addr(data_addr_out[3:0]),
    .rd_n(data_read_strobe_n), .wr_n(data_write_strobe_n),
    .dout(data_data_out), .oe(data_data_oe), .dly(dly),
    .din(data_data_in), .ack(data_acknowledge));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dt = rdata;
    rready <= 1'b0;
  endtask
  task automatic acc(input bit p, wr_e, ab, iz, input logic [31:0] ad,
                     input logic [47:0] dt);
    mem_port_pkg::mem_req_s r;
    r = '{wr_e, ab, iz, ad, dt};
    n = 0;
    low = 0;
    @(posedge aclk);
    data_req <= r;
    prog_req <= r;
    data_req_valid <= p;
    prog_req_valid <= !p;
    do begin
      @(posedge aclk);
      #1;
      n++;
      if ((p ? data_read_strobe_n & data_write_strobe_n
             : prog_read_strobe_n & prog_write_strobe_n) === 1'b0) low++;
      if (n == 1) sel = p ? data_bank_select_n : {2'h3, prog_bank_select_n};
    end while ((p ? data_done : prog_done) !== 1'b1 && n < 40);
    @(posedge aclk);
    data_req_valid <= 1'b0;
    prog_req_valid <= 1'b0;
  endtask
  function automatic int exp_n(input logic [1:0] md, input int ct, dl);
    case (md)
      2'h0: return dl + 2;
      2'h1: return ct + 2;
      2'h2: return (ct > dl ? ct : dl) + 2;
      default: return (ct < dl ? ct : dl) + 2;
    endcase
  endfunction
  // ****************************************
  // Clock, timeout, sequence
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    logic [31:0] base [4];
    base = '{32'h0, `RST_DATA_BANK1_BOUNDARY, `RST_DATA_BANK2_BOUNDARY,
             `RST_DATA_BANK3_BOUNDARY};
    seed = 53708;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {prog_req_valid, data_req_valid, bit_reverse_instr, dly} = '0;
    {prog_float_request_n, data_float_request_n, wstrb} = 6'h3F;
    {awaddr, araddr, wdata, core_mode_word, bit_reverse_addr} = '0;
    prog_req = '0;
    data_req = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_PROG_BANK1_BOUNDARY, v);
    `CHK("pbank1", {8'h00, `RST_PROG_BANK1_BOUNDARY}, v)
    for (k = 1; k < 4; k++) begin
      rd(8'(4 * k), v);
      `CHK("dbank", base[k], v)
    end
    rd(8'h1C, v);
    `CHK("unmapped", 32'h0, v)
    `CHK("rresp", 2'h2, rresp)
    wr(8'h1C, 32'h1);
    `CHK("bresp", 2'h2, bresp)
    for (k = 0; k < 16; k++) begin
      b = k % 4;
      m = 2'(k / 4);
      c = {$random(seed)} % 8;
      d = {$random(seed)} % 8;
      dly <= 3'(d);
      wr(`OFF_DATA_WAIT_CONTROL, 32'({3'(c), m}) << (5 * b));
      rd(`OFF_DATA_WAIT_CONTROL, v);
      `CHK("dwait", 32'({3'(c), m}) << (5 * b), v)
      a = base[b] + ({$random(seed)} & 32'hFFFF);
      wd = 40'({$random(seed), $random(seed)});
      acc(1, 1, 0, 0, a, 48'(wd));
      `CHK("wcycles", exp_n(m, c, d), n)
      `CHK("wstrobe", exp_n(m, c, d) - 1, low)
      `CHK("wsel", ~(4'h1 << b), sel)
      acc(1, 0, 0, 0, a, 48'h0);
      `CHK("rcycles", exp_n(m, c, d), n)
      `CHK("rdata", wd, data_rdata)
      `CHK("ahold", a, data_addr_out)
    end
    wr(`OFF_DATA_WAIT_CONTROL, 32'h0000000D);
    acc(1, 1, 0, 0, 32'h10, 48'hA5);
    acc(1, 0, 0, 0, 32'h10, 48'h0);
    acc(1, 1, 1, 0, 32'h10, 48'h5A);
    `CHK("abwstrobe", 0, low)
    acc(1, 0, 1, 0, 32'h10, 48'h0);
    `CHK("abrstrobe", 0, low)
    `CHK("abrdata", 40'hA5, data_rdata)
    acc(1, 0, 0, 0, 32'h10, 48'h0);
    `CHK("abwkept", 40'hA5, data_rdata)
    core_mode_word <= 32'h2;
    acc(1, 0, 0, 1, 32'h90000000, 48'h0);
    `CHK("brsel", 4'hE, sel)
    core_mode_word <= 32'h0;
    a = $random(seed);
    bit_reverse_addr <= a;
    bit_reverse_instr <= 1'b1;
    @(posedge aclk);
    bit_reverse_instr <= 1'b0;
    @(posedge aclk);
    #1;
    `CHK("braddr", a, data_addr_out)
    @(posedge aclk);
    data_float_request_n <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    `CHK("fpins", 1'b0, data_pins_oe)
    `CHK("fdata", 1'b0, data_data_oe)
    `CHK("ppins", 1'b1, prog_pins_oe)
    acc(0, 0, 0, 0, 32'h100, 48'h0);
    `CHK("pfree", 2, n)
    fork
      acc(1, 0, 0, 0, 32'h10, 48'h0);
      begin
        repeat (8) @(posedge aclk);
        data_float_request_n <= 1'b1;
      end
    join
    `CHK("resume", 1'b1, n > 7 && n < 12)
    `CHK("unfloat", 1'b1, data_pins_oe)
    a = 32'h100 + ({$random(seed)} & 32'h7FFF00);
    wr(`OFF_PROG_BANK1_BOUNDARY, a);
    wr(`OFF_PROG_WAIT_CONTROL, 32'h000002A0);
    acc(0, 0, 0, 0, a - 1, 48'h0);
    `CHK("pbank0", 4'hE, sel)
    `CHK("p0cycles", 2, n)
    acc(0, 0, 0, 0, a, 48'h0);
    `CHK("pbank1sel", 4'hD, sel)
    `CHK("p1cycles", 7, n)
    acc(0, 1, 0, 0, a, 48'hC3A50F1E7788);
    wr(`OFF_PROG_WAIT_CONTROL, 32'h00000060);
    acc(0, 0, 0, 0, a, 48'h0);
    `CHK("peither", 2, n)
    `CHK("prdata", 48'hC3A50F1E7788, prog_rdata)
    conclude();
  end
endmodule
`default_nettype wire
